/* File: common/flash_ctrl_pkg.sv */
// Constants, register map and command codes for the flash command controller
package flash_ctrl_pkg;

  // Clock rate in MHz
  localparam int CLK_MHZ = 50;

  // Register byte addresses
  localparam logic [31:0] ADDR_STATUS = 32'hffff0e00;
  localparam logic [31:0] ADDR_MODE = 32'hffff0804;
  localparam logic [31:0] ADDR_CMD = 32'hffff0808;
  localparam logic [31:0] ADDR_DATA = 32'hffff080c;
  localparam logic [31:0] ADDR_ADDR = 32'hffff0810;
  localparam logic [31:0] ADDR_SIGN = 32'hffff0818;
  localparam logic [31:0] ADDR_PERS = 32'hffff081c;
  localparam logic [31:0] ADDR_VOL = 32'hffff0820;

  // Reset values
  localparam logic [15:0] RST_ADDR = 16'h0000;
  localparam logic [15:0] RST_DATA = 16'h0000;
  localparam logic [23:0] RST_SIGN = 24'hffffff;
  localparam logic [31:0] RST_PERS = 32'h00000000;
  localparam logic [31:0] RST_VOL = 32'h0fffffff;
  localparam logic [31:0] NV_BLANK = 32'hffffffff;
  localparam logic [7:0] RST_CMD = 8'h00;
  localparam logic [15:0] RST_MODE = 16'h0000;

  // Status bit positions
  localparam int ST_PASS = 0;
  localparam int ST_FAIL = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_IRQ = 3;

  // Mode bit positions and key field
  localparam int MD_WREN = 3;
  localparam int MD_IRQEN = 4;
  localparam int MD_KEY_LO = 5;
  localparam logic [2:0] KEY_PROTECT = 3'h5;
  localparam logic [2:0] KEY_MASS = 3'h3;

  // Protection mask bit positions
  localparam int PM_DBG_READ = 31;
  localparam int PM_PAGE59 = 30;
  localparam int PM_PAGE58 = 29;
  localparam logic [6:0] PAGE_58 = 7'h3a;
  localparam logic [6:0] PAGE_59 = 7'h3b;

  // Highest user byte address
  localparam logic [15:0] USER_TOP = 16'h77ff;

  // Command codes
  localparam logic [7:0] CMD_NULL = 8'h00;
  localparam logic [7:0] CMD_READ = 8'h01;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_ERASE_WRITE = 8'h03;
  localparam logic [7:0] CMD_VERIFY = 8'h04;
  localparam logic [7:0] CMD_ERASE = 8'h05;
  localparam logic [7:0] CMD_MASS = 8'h06;
  localparam logic [7:0] CMD_DONE = 8'h07;
  localparam logic [7:0] CMD_SIGN = 8'h0b;
  localparam logic [7:0] CMD_PROTECT = 8'h0c;
  localparam logic [7:0] CMD_PING = 8'h0f;

  // Operation times and derived cycle counts
  localparam int T_WRITE_US = 50;
  localparam int WRITE_CYC = T_WRITE_US * CLK_MHZ;
  localparam int T_ERASE_WRITE_MS = 24;
  localparam int ERASE_WRITE_CYC = T_ERASE_WRITE_MS * 1000 * CLK_MHZ;
  localparam int SIGN_CYC = 16389;
  localparam int PAGE_ERASE_CYC = 20000;
  localparam int MASS_ERASE_CYC = 40000;

  // Signature feedback taps
  localparam logic [23:0] SIG_POLY = 24'he10000;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RD_WAIT = 3'b001,
    ST_RD_TAKE = 3'b010,
    ST_TIMED = 3'b011,
    ST_SIG_RUN = 3'b100,
    ST_FINISH = 3'b101
  } seq_state_t;

endpackage : flash_ctrl_pkg

/* File: rtl/lfsr_signature.sv */
// Twenty-four bit shift register that folds flash words into a signature
`timescale 1ns/1ps
module lfsr_signature (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control
  input wire logic clear_in,
  input wire logic step_in,
  input wire logic [15:0] word_in,
  // Result
  output logic [23:0] sig_out
);

  logic [23:0] sig_q;
  logic [23:0] sig_d;

  // Galois step with the incoming word mixed into the low sixteen bits
  always_comb begin
    sig_d = {sig_q[22:0], 1'b0} ^ (sig_q[23] ? flash_ctrl_pkg::SIG_POLY : 24'h000000);
    sig_d = sig_d ^ {8'h00, word_in};
  end

  // Seeded with all ones so a blank array still gives a nonzero result
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sig_q <= flash_ctrl_pkg::RST_SIGN;
    end else if (clear_in) begin
      sig_q <= flash_ctrl_pkg::RST_SIGN;
    end else if (step_in) begin
      sig_q <= sig_d;
    end
  end

  assign sig_out = sig_q;

endmodule : lfsr_signature

/* File: rtl/flash_command_protect_ctrl.sv */
// Flash command sequencer with write protection masks and signature engine
//
// Contract
// [R1] Read command loads addressed word into data
// [R2] Write command programs data word, 50 us
// [R3] Erase-write erases page then programs, 24 ms
// [R4] Verify compares word, result in fail bit
// [R5] Page erase clears addressed page only
// [R6] Mass erase user space, needs guard key
// [R7] Signature runs 16389 cycles into signature register
// [R8] Protect commits persistent mask once, key reopens
// [R9] Ping does nothing but raises interrupt
// [R10] Command reads 0x07 after codes 0x00-0x06
// [R11] Data register holds 16-bit read/write word
// [R12] Address beyond 0x77ff raises data abort
// [R13] Signature register 24 bit, read-only, all ones
// [R14] Persistent mask acts after reset, key-gated
// [R15] Volatile mask acts at once, reset default
// [R16] Bit 31 gates debug-port code reads
// [R17] Bits 30, 29 gate pages 59, 58
// [R18] Bits 28:0 gate page pairs
// [R19] Fail/pass flags set, cleared by status read
// [R20] Status bit 2 shows busy
// [R21] Mode bit 3 enables erase and write
// [R22] Mode bit 4 raises interrupt, status bit 3
// [R23] Reserved codes start nothing, change nothing; the code sets the fail flag for them
// [R24] Protected page write or erase fails
`timescale 1ns/1ps
module flash_command_protect_ctrl #(
  parameter int ERASE_WRITE_CYCLES = flash_ctrl_pkg::ERASE_WRITE_CYC,
  parameter int SIGN_CYCLES = flash_ctrl_pkg::SIGN_CYC,
  parameter int PAGE_ERASE_CYCLES = flash_ctrl_pkg::PAGE_ERASE_CYC,
  parameter int MASS_ERASE_CYCLES = flash_ctrl_pkg::MASS_ERASE_CYC
) (
  // Clock and resets
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic por_in,
  // Processor register port
  input wire logic [31:0] mmr_addr_in,
  input wire logic mmr_wr_in,
  input wire logic mmr_rd_in,
  input wire logic [31:0] mmr_wdata_in,
  output logic [31:0] mmr_rdata_out,
  output logic abort_out,
  output logic irq_out,
  // Flash array side
  output logic [14:0] fl_addr_out,
  output logic [15:0] fl_wdata_out,
  output logic fl_read_out,
  output logic fl_prog_out,
  output logic fl_erase_out,
  output logic fl_mass_out,
  input wire logic [15:0] fl_rdata_in,
  // Debug port read permission
  output logic dbg_read_ok_out
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  flash_ctrl_pkg::seq_state_t state_q; // Sequencer state
  logic [7:0] cmd_q; // Command register
  logic [15:0] mode_q; // Mode register
  logic [15:0] data_q; // Data word
  logic [15:0] addr_q; // Byte address
  logic [23:0] sign_q; // Signature result
  logic [31:0] pers_q; // Persistent mask staging
  logic [31:0] vol_q; // Volatile mask
  logic [31:0] nv_q; // Non-volatile copy, survives rst_in
  logic nv_locked_q; // Protect already committed
  logic [31:0] pers_act_q; // Persistent mask in force
  logic load_nv_q; // Load pending after reset release
  logic [3:0] stat_q; // Status flags
  logic [20:0] cnt_q; // Operation timer
  logic [14:0] sig_addr_q; // Signature walk address
  logic sig_step_q; // Word valid for signature
  logic done_q; // Finish pulse request
  logic ok_q; // Outcome of current command
  logic ping_q; // Current command is ping
  logic [23:0] sig_val; // Shift register output
  logic wr_cmd, wr_mode, wr_data, wr_addr, wr_pers, wr_vol, rd_stat;
  logic [31:0] eff_mask; // Combined protection
  logic [6:0] page; // Addressed page
  logic page_ok; // Page writable
  logic addr_ok; // Address inside user space
  logic idle;
  logic fin; // Finishing cycle
  logic wren; // Erase and write allowed
  logic [2:0] key; // Mode key field
  logic [7:0] wcode; // Code being written

  ////////////////////////////////////////////////////////////////////////
  // Decode and protection lookup

  assign idle = (state_q == flash_ctrl_pkg::ST_IDLE);
  assign fin = (state_q == flash_ctrl_pkg::ST_FINISH);
  assign wren = mode_q[flash_ctrl_pkg::MD_WREN];
  assign key = mode_q[flash_ctrl_pkg::MD_KEY_LO +: 3];
  assign wcode = mmr_wdata_in[7:0];
  assign eff_mask = pers_act_q & vol_q; // R16 R17 R18
  assign page = addr_q[15:9];
  assign addr_ok = (addr_q <= flash_ctrl_pkg::USER_TOP); // R12

  // Write strobes by address
  assign wr_cmd = mmr_wr_in && mmr_addr_in == flash_ctrl_pkg::ADDR_CMD;
  assign wr_mode = mmr_wr_in && mmr_addr_in == flash_ctrl_pkg::ADDR_MODE;
  assign wr_data = mmr_wr_in && mmr_addr_in == flash_ctrl_pkg::ADDR_DATA;
  assign wr_addr = mmr_wr_in && mmr_addr_in == flash_ctrl_pkg::ADDR_ADDR;
  assign wr_pers = mmr_wr_in && mmr_addr_in == flash_ctrl_pkg::ADDR_PERS;
  assign wr_vol = mmr_wr_in && mmr_addr_in == flash_ctrl_pkg::ADDR_VOL;

  assign rd_stat = mmr_rd_in && (mmr_addr_in == flash_ctrl_pkg::ADDR_STATUS);

  // Page to mask bit: pairs below 58, single bits for 58 and 59
  always_comb begin
    if (page == flash_ctrl_pkg::PAGE_59) begin
      page_ok = eff_mask[flash_ctrl_pkg::PM_PAGE59]; // R17
    end else if (page == flash_ctrl_pkg::PAGE_58) begin
      page_ok = eff_mask[flash_ctrl_pkg::PM_PAGE58]; // R17
    end else begin
      page_ok = eff_mask[page[5:1]]; // R18
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Plain configuration registers

  // Mode register, free to change at any time
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_q <= flash_ctrl_pkg::RST_MODE;
    end else if (wr_mode) begin
      mode_q <= mmr_wdata_in[15:0];
    end
  end

  // Address register; held while busy so the target stays stable
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      addr_q <= flash_ctrl_pkg::RST_ADDR;
    end else if (wr_addr && idle) begin
      addr_q <= mmr_wdata_in[15:0];
    end
  end

  // Volatile mask acts immediately, no key
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      vol_q <= flash_ctrl_pkg::RST_VOL; // R15
    end else if (wr_vol) begin
      vol_q <= mmr_wdata_in; // R15
    end
  end

  // Staging moves only under the protect key
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pers_q <= flash_ctrl_pkg::RST_PERS;
    end else if (wr_pers && key == flash_ctrl_pkg::KEY_PROTECT) begin
      pers_q <= mmr_wdata_in; // R14
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Non-volatile protection store

  // Only power-on, commit or mass erase change it
  always_ff @(posedge clk_in or posedge por_in) begin
    if (por_in) begin
      nv_q <= flash_ctrl_pkg::NV_BLANK;
      nv_locked_q <= 1'b0;
    end else if (fin && ok_q && cmd_q == flash_ctrl_pkg::CMD_PROTECT) begin
      nv_q <= pers_q; // R8
      nv_locked_q <= 1'b1; // R8
    end else if (fin && ok_q && cmd_q == flash_ctrl_pkg::CMD_MASS) begin
      nv_q <= flash_ctrl_pkg::NV_BLANK; // R8
      nv_locked_q <= 1'b0;
    end
  end

  // Stored mask takes force one edge after reset
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      load_nv_q <= 1'b1;
      pers_act_q <= flash_ctrl_pkg::NV_BLANK;
    end else if (load_nv_q) begin
      load_nv_q <= 1'b0;
      pers_act_q <= nv_q; // R14
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command sequencer

  // Starts, times and finishes each command
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= flash_ctrl_pkg::ST_IDLE;
      cmd_q <= flash_ctrl_pkg::RST_CMD;
      cnt_q <= 21'h0;
      ok_q <= 1'b0;
      ping_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        flash_ctrl_pkg::ST_IDLE: begin
          // Writes while busy are dropped
          if (wr_cmd) begin
            cmd_q <= wcode;
            ping_q <= 1'b0;
            ok_q <= 1'b1;
            cnt_q <= 21'h0;
            case (wcode)
              flash_ctrl_pkg::CMD_NULL: begin
                state_q <= flash_ctrl_pkg::ST_FINISH;
              end
              flash_ctrl_pkg::CMD_READ, flash_ctrl_pkg::CMD_VERIFY: begin
                ok_q <= addr_ok; // R12
                state_q <= addr_ok ? flash_ctrl_pkg::ST_RD_WAIT : flash_ctrl_pkg::ST_FINISH;
              end
              flash_ctrl_pkg::CMD_WRITE, flash_ctrl_pkg::CMD_ERASE_WRITE, flash_ctrl_pkg::CMD_ERASE: begin
                // Refused if disabled, out of range or protected
                if (!wren || !addr_ok || !page_ok) begin // R21 R24
                  ok_q <= 1'b0;
                  state_q <= flash_ctrl_pkg::ST_FINISH;
                end else begin
                  state_q <= flash_ctrl_pkg::ST_TIMED;
                  if (wcode == flash_ctrl_pkg::CMD_WRITE) begin
                    cnt_q <= 21'(flash_ctrl_pkg::WRITE_CYC - 1); // R2
                  end else if (wcode == flash_ctrl_pkg::CMD_ERASE_WRITE) begin
                    cnt_q <= 21'(ERASE_WRITE_CYCLES - 1); // R3
                  end else begin
                    cnt_q <= 21'(PAGE_ERASE_CYCLES - 1); // R5
                  end
                end
              end
              flash_ctrl_pkg::CMD_MASS: begin
                // Guard key in the mode field must be present
                if (!wren || key != flash_ctrl_pkg::KEY_MASS) begin // R6 R21
                  ok_q <= 1'b0;
                  state_q <= flash_ctrl_pkg::ST_FINISH;
                end else begin
                  cnt_q <= 21'(MASS_ERASE_CYCLES - 1); // R6
                  state_q <= flash_ctrl_pkg::ST_TIMED;
                end
              end
              flash_ctrl_pkg::CMD_SIGN: begin
                cnt_q <= 21'(SIGN_CYCLES - 1); // R7
                state_q <= flash_ctrl_pkg::ST_SIG_RUN;
              end
              flash_ctrl_pkg::CMD_PROTECT: begin
                // Once only, unless the protect key reopens it
                ok_q <= !nv_locked_q || key == flash_ctrl_pkg::KEY_PROTECT; // R8
                state_q <= flash_ctrl_pkg::ST_FINISH;
              end
              flash_ctrl_pkg::CMD_PING: begin
                ping_q <= 1'b1; // R9
                state_q <= flash_ctrl_pkg::ST_FINISH;
              end
              default: begin
                // Reserved: fails, runs nothing
                ok_q <= 1'b0; // R23
                state_q <= flash_ctrl_pkg::ST_FINISH;
              end
            endcase
          end
        end
        flash_ctrl_pkg::ST_RD_WAIT: begin
          state_q <= flash_ctrl_pkg::ST_RD_TAKE;
        end
        flash_ctrl_pkg::ST_RD_TAKE: begin
          if (cmd_q == flash_ctrl_pkg::CMD_VERIFY) begin
            ok_q <= (fl_rdata_in == data_q); // R4
          end
          state_q <= flash_ctrl_pkg::ST_FINISH;
        end
        flash_ctrl_pkg::ST_TIMED, flash_ctrl_pkg::ST_SIG_RUN: begin
          if (cnt_q == 21'h0) begin
            state_q <= flash_ctrl_pkg::ST_FINISH;
          end else begin
            cnt_q <= cnt_q - 21'h1;
          end
        end
        flash_ctrl_pkg::ST_FINISH: begin
          done_q <= 1'b1;
          if (cmd_q <= flash_ctrl_pkg::CMD_MASS) begin
            cmd_q <= flash_ctrl_pkg::CMD_DONE; // R10
          end else begin
            cmd_q <= flash_ctrl_pkg::CMD_NULL;
          end
          state_q <= flash_ctrl_pkg::ST_IDLE;
        end
        default: begin
          state_q <= flash_ctrl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data word

  // Written when idle, filled by read
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_q <= flash_ctrl_pkg::RST_DATA;
    end else if (state_q == flash_ctrl_pkg::ST_RD_TAKE && cmd_q == flash_ctrl_pkg::CMD_READ) begin
      data_q <= fl_rdata_in; // R1 R11
    end else if (wr_data && idle) begin
      data_q <= mmr_wdata_in[15:0]; // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flash array strobes

  // Erase at op start, program at its end: erase-write erases first
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      fl_read_out <= 1'b0;
      fl_prog_out <= 1'b0;
      fl_erase_out <= 1'b0;
      fl_mass_out <= 1'b0;
      fl_addr_out <= 15'h0000;
      fl_wdata_out <= 16'h0000;
      sig_addr_q <= 15'h0000;
      sig_step_q <= 1'b0;
    end else begin
      fl_read_out <= (idle && wr_cmd && addr_ok &&
                      (wcode == flash_ctrl_pkg::CMD_READ || wcode == flash_ctrl_pkg::CMD_VERIFY)) ||
                     (state_q == flash_ctrl_pkg::ST_SIG_RUN); // R1 R4
      fl_erase_out <= idle && wr_cmd && wren && addr_ok && page_ok &&
                      (wcode == flash_ctrl_pkg::CMD_ERASE_WRITE || wcode == flash_ctrl_pkg::CMD_ERASE); // R3 R5 R24
      fl_mass_out <= idle && wr_cmd && wren && key == flash_ctrl_pkg::KEY_MASS &&
                     wcode == flash_ctrl_pkg::CMD_MASS; // R6
      fl_prog_out <= state_q == flash_ctrl_pkg::ST_TIMED && cnt_q == 21'h000000 &&
                     (cmd_q == flash_ctrl_pkg::CMD_WRITE || cmd_q == flash_ctrl_pkg::CMD_ERASE_WRITE); // R2 R3
      fl_wdata_out <= data_q;
      sig_step_q <= (state_q == flash_ctrl_pkg::ST_SIG_RUN);
      // Signature walks the array one word a cycle
      if (state_q == flash_ctrl_pkg::ST_SIG_RUN) begin
        fl_addr_out <= sig_addr_q;
        sig_addr_q <= sig_addr_q + 15'h0001;
      end else begin
        fl_addr_out <= addr_q[15:1];
        sig_addr_q <= 15'h0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Signature engine

  lfsr_signature u_sig (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .clear_in(idle && wr_cmd),
    .step_in(sig_step_q),
    .word_in(fl_rdata_in),
    .sig_out(sig_val)
  );

  // Result lands when signature finishes
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sign_q <= flash_ctrl_pkg::RST_SIGN; // R13
    end else if (fin && cmd_q == flash_ctrl_pkg::CMD_SIGN) begin
      sign_q <= sig_val; // R7 R13
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status, interrupt and abort

  // Hardware set beats a clearing status read in the same cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      stat_q <= 4'h0;
      irq_out <= 1'b0;
      abort_out <= 1'b0;
    end else begin
      stat_q[flash_ctrl_pkg::ST_BUSY] <= !fin && !(idle && !wr_cmd); // R20
      if (fin && ok_q) begin
        stat_q[flash_ctrl_pkg::ST_PASS] <= 1'b1; // R19
      end else if (rd_stat) begin
        stat_q[flash_ctrl_pkg::ST_PASS] <= 1'b0; // R19
      end
      if (fin && !ok_q) begin
        stat_q[flash_ctrl_pkg::ST_FAIL] <= 1'b1; // R19 R4 R24
      end else if (rd_stat) begin
        stat_q[flash_ctrl_pkg::ST_FAIL] <= 1'b0; // R19
      end
      if (fin && mode_q[flash_ctrl_pkg::MD_IRQEN]) begin
        stat_q[flash_ctrl_pkg::ST_IRQ] <= 1'b1; // R22
      end else if (rd_stat) begin
        stat_q[flash_ctrl_pkg::ST_IRQ] <= 1'b0; // R22
      end
      // Ping always interrupts
      irq_out <= fin && (mode_q[flash_ctrl_pkg::MD_IRQEN] || ping_q); // R9 R22
      abort_out <= idle && wr_cmd && !addr_ok && wcode >= flash_ctrl_pkg::CMD_READ &&
                   wcode <= flash_ctrl_pkg::CMD_ERASE; // R12
    end
  end

  // Debug code reads need bit 31
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dbg_read_ok_out <= 1'b0;
    end else begin
      dbg_read_ok_out <= eff_mask[flash_ctrl_pkg::PM_DBG_READ]; // R16
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe; unmapped reads give zero

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mmr_rdata_out <= 32'h00000000;
    end else if (mmr_rd_in) begin
      if (mmr_addr_in == flash_ctrl_pkg::ADDR_STATUS) begin
        mmr_rdata_out <= 32'(stat_q);
      end else if (mmr_addr_in == flash_ctrl_pkg::ADDR_MODE) begin
        mmr_rdata_out <= 32'(mode_q);
      end else if (mmr_addr_in == flash_ctrl_pkg::ADDR_CMD) begin
        mmr_rdata_out <= 32'(cmd_q); // R10
      end else if (mmr_addr_in == flash_ctrl_pkg::ADDR_DATA) begin
        mmr_rdata_out <= 32'(data_q);
      end else if (mmr_addr_in == flash_ctrl_pkg::ADDR_ADDR) begin
        mmr_rdata_out <= 32'(addr_q);
      end else if (mmr_addr_in == flash_ctrl_pkg::ADDR_SIGN) begin
        mmr_rdata_out <= {8'h00, sign_q}; // R13
      end else if (mmr_addr_in == flash_ctrl_pkg::ADDR_PERS) begin
        mmr_rdata_out <= pers_q;
      end else if (mmr_addr_in == flash_ctrl_pkg::ADDR_VOL) begin
        mmr_rdata_out <= vol_q;
      end else begin
        mmr_rdata_out <= 32'h00000000;
      end
    end
  end

endmodule : flash_command_protect_ctrl

/* File: tb/flash_ctrl_properties.sv */
// Port-level checks for the flash command controller
`timescale 1ns/1ps
module flash_ctrl_properties (
  // Clock, reset and register port
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic mmr_rd_in,
  input wire logic [31:0] mmr_rdata_out,
  input wire logic abort_out,
  input wire logic irq_out,
  // Array strobes
  input wire logic [14:0] fl_addr_out,
  input wire logic fl_prog_out,
  input wire logic fl_erase_out,
  input wire logic fl_mass_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  chk_abort_pulse: assert property (abort_out |=> !abort_out) else $error("abort too long");
  chk_irq_pulse: assert property (irq_out |=> !irq_out) else $error("irq too long");
  chk_prog_pulse: assert property (fl_prog_out |=> !fl_prog_out) else $error("prog too long");
  chk_mass_pulse: assert property (fl_mass_out |=> !fl_mass_out) else $error("mass too long");
  chk_mass_alone: assert property (fl_mass_out |-> !fl_prog_out && !fl_erase_out) else $error("mixed");
  chk_prog_user: assert property (fl_prog_out |-> fl_addr_out <= 15'h3bff) else $error("prog range");
  chk_erase_user: assert property (fl_erase_out |-> fl_addr_out[14:8] <= 7'h3b) else $error("erase range");
  // Read data only moves after a read strobe
  chk_rdata_hold: assert property (!$past(mmr_rd_in) |-> $stable(mmr_rdata_out)) else $error("rdata moved");
  cover property (fl_prog_out);
  cover property (irq_out);
  cover property (abort_out);
endmodule : flash_ctrl_properties
bind flash_command_protect_ctrl flash_ctrl_properties flash_ctrl_properties_i (.clk_in(clk_in), .rst_in(rst_in),
  .mmr_rd_in(mmr_rd_in), .mmr_rdata_out(mmr_rdata_out), .abort_out(abort_out), .irq_out(irq_out),
  .fl_addr_out(fl_addr_out), .fl_prog_out(fl_prog_out), .fl_erase_out(fl_erase_out), .fl_mass_out(fl_mass_out));

/* File: tb/flash_array_model.sv */
// Behavioural flash array answering the controller strobes
`timescale 1ns/1ps
module flash_array_model (
  input wire logic clk_in,
  input wire logic [14:0] fl_addr_in,
  input wire logic [15:0] fl_wdata_in,
  input wire logic fl_read_in,
  input wire logic fl_prog_in,
  input wire logic fl_erase_in,
  input wire logic fl_mass_in,
  output logic [15:0] fl_rdata_out
);
  logic [15:0] mem_q [0:16383];
  initial begin
    for (int i = 0; i < 16384; i++) mem_q[i] = 16'hffff;
    fl_rdata_out = 16'h0000;
  end
  // Data only in the cycle after a read strobe, scrambled otherwise
  always @(posedge clk_in) begin
    fl_rdata_out <= fl_read_in ? mem_q[fl_addr_in] : ~fl_rdata_out;
    if (fl_prog_in) mem_q[fl_addr_in] <= mem_q[fl_addr_in] & fl_wdata_in;
    // Programming only clears bits, so a missing erase shows up
    if (fl_erase_in) for (int j = 0; j < 256; j++) mem_q[{fl_addr_in[14:8], j[7:0]}] <= 16'hffff;
    if (fl_mass_in) for (int j = 0; j < 15360; j++) mem_q[j] <= 16'hffff;
  end
endmodule : flash_array_model

/* File: tb/tb_top.sv */
// Self-checking bench for the flash command controller
`timescale 1ns/1ps
module tb_top;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic por_in = 1'b1;
  logic mmr_wr_in = 1'b0;
  logic mmr_rd_in = 1'b0;
  logic [31:0] mmr_addr_in = 32'h0;
  logic [31:0] mmr_wdata_in = 32'h0;
  logic [31:0] mmr_rdata_out, rv;
  logic abort_out, irq_out, fl_read_out, fl_prog_out, fl_erase_out, fl_mass_out, dbg_read_ok_out;
  logic [14:0] fl_addr_out;
  logic [15:0] fl_wdata_out, fl_rdata_in;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_abort = 0;
  typedef struct {logic [7:0] c; logic [15:0] d; logic [3:0] st; logic [15:0] rd;} row_t;
  // Command, data, status, data after; address 0x10
  row_t rows [9] = '{'{8'h02, 16'h1234, 4'h9, 16'h1234}, '{8'h01, 16'h0, 4'h9, 16'h1234},
    '{8'h04, 16'h1234, 4'h9, 16'h1234}, '{8'h04, 16'h4321, 4'ha, 16'h4321},
    '{8'h05, 16'h0, 4'h9, 16'h0}, '{8'h01, 16'h0, 4'h9, 16'hffff},
    '{8'h03, 16'haa, 4'h9, 16'haa}, '{8'h0f, 16'h0, 4'h9, 16'h0}, '{8'h08, 16'h0, 4'ha, 16'h0}};
  always #10 clk_in = ~clk_in;
  always @(posedge clk_in) if (abort_out === 1'b1) n_abort++;
  flash_command_protect_ctrl #(.ERASE_WRITE_CYCLES(20), .SIGN_CYCLES(40), .PAGE_ERASE_CYCLES(10),
    .MASS_ERASE_CYCLES(10)) flash_command_protect_ctrl_i (.clk_in(clk_in), .rst_in(rst_in), .por_in(por_in),
    .mmr_addr_in(mmr_addr_in), .mmr_wr_in(mmr_wr_in), .mmr_rd_in(mmr_rd_in), .mmr_wdata_in(mmr_wdata_in),
    .mmr_rdata_out(mmr_rdata_out), .abort_out(abort_out), .irq_out(irq_out), .fl_addr_out(fl_addr_out),
    .fl_wdata_out(fl_wdata_out), .fl_read_out(fl_read_out), .fl_prog_out(fl_prog_out), .fl_erase_out(fl_erase_out),
    .fl_mass_out(fl_mass_out), .fl_rdata_in(fl_rdata_in), .dbg_read_ok_out(dbg_read_ok_out));
  flash_array_model flash_array_model_i (.clk_in(clk_in), .fl_addr_in(fl_addr_out), .fl_wdata_in(fl_wdata_out),
    .fl_read_in(fl_read_out), .fl_prog_in(fl_prog_out), .fl_erase_in(fl_erase_out), .fl_mass_in(fl_mass_out),
    .fl_rdata_out(fl_rdata_in));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : cmp
  // One-cycle strobes, held until the sampling edge
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_in);
    mmr_addr_in <= a;
    mmr_wdata_in <= d;
    mmr_wr_in <= 1'b1;
    @(posedge clk_in);
    mmr_wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a);
    @(posedge clk_in);
    mmr_addr_in <= a;
    mmr_rd_in <= 1'b1;
    @(posedge clk_in);
    mmr_rd_in <= 1'b0;
    @(posedge clk_in);
    rv = mmr_rdata_out;
  endtask : rd
  // Issue a command and poll status until idle; rv keeps the final status
  task automatic run(input logic [7:0] c, input logic [15:0] a, input logic [15:0] d);
    wr(flash_ctrl_pkg::ADDR_ADDR, {16'h0, a});
    wr(flash_ctrl_pkg::ADDR_DATA, {16'h0, d});
    wr(flash_ctrl_pkg::ADDR_CMD, {24'h0, c});
    rd(flash_ctrl_pkg::ADDR_STATUS);
    for (int i = 0; i < 3000 && rv[2] !== 1'b0; i++) rd(flash_ctrl_pkg::ADDR_STATUS);
    if (rv[2] !== 1'b0) begin
      n_mismatch++;
      finish_test();
    end
  endtask : run
  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    por_in <= 1'b0;
    rd(flash_ctrl_pkg::ADDR_SIGN);
    cmp(rv, 32'h00ffffff);
    rd(flash_ctrl_pkg::ADDR_VOL);
    cmp(rv, 32'h0fffffff);
    cmp(dbg_read_ok_out, 1'b0);
    rd(32'hffff0800);
    cmp(rv, 32'h0);
    wr(flash_ctrl_pkg::ADDR_MODE, 32'h18);
    foreach (rows[i]) begin
      run(rows[i].c, 16'h10, rows[i].d);
      cmp(rv[3:0], rows[i].st);
      rd(flash_ctrl_pkg::ADDR_CMD);
      cmp(rv, rows[i].c < 8'h07 ? 32'h7 : 32'h0);
      rd(flash_ctrl_pkg::ADDR_DATA);
      cmp(rv[15:0], rows[i].rd);
      $display("row %0d done", i);
    end
    // Out-of-range read aborts and fails
    run(8'h01, 16'h7800, 16'h0);
    cmp(n_abort, 1);
    cmp(rv[3:0], 4'ha);
    // Page pair 0/1 locked by the volatile mask
    wr(flash_ctrl_pkg::ADDR_VOL, 32'h0ffffffe);
    run(8'h02, 16'h10, 16'h0);
    cmp(rv[3:0], 4'ha);
    run(8'h01, 16'h10, 16'h0);
    rd(flash_ctrl_pkg::ADDR_DATA);
    cmp(rv[15:0], 16'haa);
    // Erase refused with write enable clear
    wr(flash_ctrl_pkg::ADDR_MODE, 32'h10);
    run(8'h05, 16'h400, 16'h0);
    cmp(rv[3:0], 4'ha);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(flash_ctrl_pkg::ADDR_VOL);
    cmp(rv, 32'h0fffffff);
    $display("hand tests done");
    finish_test();
  end
endmodule : tb_top
